// ==== rtl/dpl_lane.sv ====
// Our own choices: register access over Wishbone and the address map.
`timescale 1ns/100ps
// Function
// R01 - HS data ignored while request low
// R02 - One byte taken per ready byte-clock edge
// R03 - Request drop stops burst, ready falls
// R04 - Clock lane request needed before HS
// R05 - Start delay covers LP, prepare, zero, crossing
// R06 - Escape request plus select enters LP data
// R07 - LP byte moves on valid and ready
// R08 - Ready falls after escape request drops
// R09 - Trigger code sent on escape request
// R10 - One-cycle command pulse starts data-lane sleep
// R11 - Data indicator low after sleep command sent
// R12 - Exit raises indicator, drives mark-one
// R13 - Request held through wakeup after exit
// R14 - Clock indicator low after entry sequence
// R15 - Clock exit raises indicator, drives mark-one
// R16 - Receive active, sync pulse, then bytes
// R17 - Trailing filler byte, active and valid fall
// R18 - Lanes independent, no alignment or deskew
// R19 - Single-bit start error flagged with sync
// R20 - Multi-bit start error, no sync, payload passed
// R21 - Escape clock from line, data flag held
// R22 - LP receive byte valid only with strobe
// R23 - Wakeup mark-one lasts at least 1 ms
module dpl_lane import dpl_pkg::*; #(
  parameter int unsigned WAKEUP_CYCLES = WAKEUP_CYC
) (
  input logic CLK,
  input logic RST,
  input logic CYC_I,
  input logic STB_I,
  input logic WE_I,
  input logic [3:0] ADR_I,
  input logic [3:0] SEL_I,
  input logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  input logic TX_BYTE_CLK,
  input logic TX_HS_REQ,
  input logic [7:0] TX_HS_DATA,
  input logic TX_CLK_HS_REQ,
  output logic TX_HS_READY,
  output logic TX_HS_LINE_EN,
  output logic [7:0] TX_HS_LINE_DATA,
  input logic TX_ESC_CLK,
  input logic TX_ESC_REQ,
  input logic TX_LPD_SEL,
  input logic TX_ESC_VALID,
  input logic [7:0] TX_ESC_DATA,
  input logic [3:0] TX_TRIGGER,
  input logic TX_ULP_CMD,
  input logic TX_ULP_EXIT,
  output logic TX_ESC_READY,
  output logic TX_ULP_ACTIVE_N,
  output logic [1:0] TX_LP_LINE,
  input logic TX_CLK_ULP_REQ,
  input logic TX_CLK_ULP_EXIT,
  output logic TX_CLK_ULP_ACTIVE_N,
  output logic [1:0] TX_CLK_LP_LINE,
  input logic RX_BYTE_CLK,
  input logic RX_HS_LINE,
  input logic [7:0] RX_HS_LINE_DATA,
  input logic [1:0] RX_LP_LINE,
  output logic RX_ACTIVE,
  output logic RX_SYNC,
  output logic RX_VALID,
  output logic [7:0] RX_DATA,
  output logic RX_ERR_START,
  output logic RX_ERR_START_SYNC,
  output logic RX_ESC_CLK,
  output logic RX_LPD,
  output logic RX_ESC_VALID,
  output logic [7:0] RX_ESC_DATA
);
  localparam int WW = $clog2(WAKEUP_CYCLES + 1);

  function automatic logic [3:0] bit_errors(input logic [7:0] b);
    logic [7:0] x;
    x = b ^ START_PATTERN;
    bit_errors = 4'h0;
    for (int i = 0; i < 8; i++) bit_errors = bit_errors + 4'(x[i]);
  endfunction : bit_errors

  function automatic logic [1:0] entry_state(input logic [2:0] i);
    unique case (i[1:0])
      2'h0: entry_state = LP10;
      2'h1: entry_state = LP00;
      2'h2: entry_state = LP01;
      2'h3: entry_state = LP00;
    endcase
  endfunction : entry_state

  function automatic logic [7:0] trig_cmd(input logic [3:0] t);
    if (t[0]) trig_cmd = TRIG0_CMD;
    else if (t[1]) trig_cmd = TRIG1_CMD;
    else if (t[2]) trig_cmd = TRIG2_CMD;
    else trig_cmd = TRIG3_CMD;
  endfunction : trig_cmd

  // All pins except the Wishbone bus are outside CLK; data uses the stage older than the clock edge
  logic [2:0] c_s1, c_s2, c_s3;
  logic [39:0] d_s1, d_s2, d_s3;
  logic hs_req, clk_hs_req, esc_req, lpd_sel, esc_valid, ulp_cmd, ulp_exit, cu_req, cu_exit, rx_hs;
  logic [7:0] hs_data, esc_data, rx_hs_data;
  logic [3:0] trig;
  logic [1:0] rx_lp;
  logic txb_rise, esc_rise, rxb_rise;
  always_ff @(posedge CLK) begin
    c_s1 <= {TX_BYTE_CLK, TX_ESC_CLK, RX_BYTE_CLK};
    c_s2 <= c_s1;
    c_s3 <= c_s2;
    d_s1 <= {TX_HS_REQ, TX_HS_DATA, TX_CLK_HS_REQ, TX_ESC_REQ, TX_LPD_SEL, TX_ESC_VALID, TX_ESC_DATA, TX_TRIGGER,
             TX_ULP_CMD, TX_ULP_EXIT, TX_CLK_ULP_REQ, TX_CLK_ULP_EXIT, RX_HS_LINE, RX_HS_LINE_DATA, RX_LP_LINE};
    d_s2 <= d_s1;
    d_s3 <= d_s2;
  end
  assign {hs_req, hs_data, clk_hs_req, esc_req, lpd_sel, esc_valid, esc_data, trig,
          ulp_cmd, ulp_exit, cu_req, cu_exit, rx_hs, rx_hs_data, rx_lp} = d_s3;
  assign txb_rise = c_s2[2] & ~c_s3[2];
  assign esc_rise = c_s2[1] & ~c_s3[1];
  assign rxb_rise = c_s2[0] & ~c_s3[0];

  // Wishbone slave: one wait state, unmapped reads zero
  logic [1:0] ctrl;
  always_ff @(posedge CLK) begin
    if (RST) begin
      ACK_O <= 1'b0;
      DAT_O <= 32'h0000_0000;
    end else begin
      ACK_O <= CYC_I & STB_I & ~ACK_O;
      unique case (ADR_I)
        REG_CTRL: DAT_O <= {30'h0000_0000, ctrl};
        REG_STATUS: DAT_O <= {24'h00_0000, RX_LPD, RX_ACTIVE, TX_CLK_ULP_ACTIVE_N, TX_ULP_ACTIVE_N,
                              TX_ESC_READY, TX_HS_LINE_EN, TX_HS_READY, 1'b0};
        default: DAT_O <= 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge CLK) begin
    if (RST) ctrl <= CTRL_RESET;
    else if (CYC_I && STB_I && WE_I && ACK_O && ADR_I == REG_CTRL && SEL_I[0]) ctrl <= DAT_I[1:0];
  end

  // High-speed transmit
  dpl_hs_t hs_st;
  logic [7:0] hs_cnt;
  always_ff @(posedge CLK) begin
    if (RST) begin
      hs_st <= HS_IDLE;
      hs_cnt <= 8'h00;
      TX_HS_LINE_EN <= 1'b0;
      TX_HS_LINE_DATA <= 8'h00;
    end else begin
      unique case (hs_st)
        HS_IDLE: if (hs_req && clk_hs_req && ctrl[CTRL_HS_EN]) begin // [R04] [R01]
          hs_st <= HS_START;
          hs_cnt <= 8'(STARTUP_CYC - 1);
          TX_HS_LINE_EN <= 1'b1;
          TX_HS_LINE_DATA <= 8'h00;
        end
        HS_START: if (hs_cnt != 8'h00) hs_cnt <= hs_cnt - 8'h01; // [R05]
          else hs_st <= HS_SEND;
        HS_SEND: if (!hs_req) begin // [R03]
          hs_st <= HS_IDLE;
          TX_HS_LINE_EN <= 1'b0;
        end else if (txb_rise) TX_HS_LINE_DATA <= hs_data; // [R02]
        default: hs_st <= HS_IDLE;
      endcase
    end
  end
  assign TX_HS_READY = (hs_st == HS_SEND);

  // Escape transmit on the data lane
  dpl_esc_t esc_st;
  dpl_mode_t esc_mode;
  logic [7:0] esc_sh;
  logic [3:0] esc_bits;
  logic [2:0] esc_ent;
  logic esc_half;
  logic [WW-1:0] wake;
  always_ff @(posedge CLK) begin
    if (RST) begin
      esc_st <= E_IDLE;
      esc_mode <= M_TRIG;
      esc_sh <= 8'h00;
      esc_bits <= 4'h0;
      esc_ent <= 3'h0;
      esc_half <= 1'b0;
      wake <= '0;
      TX_LP_LINE <= LP11;
      TX_ULP_ACTIVE_N <= 1'b1;
    end else begin
      unique case (esc_st)
        E_IDLE: if (esc_rise && esc_req && (ulp_cmd || lpd_sel || trig != 4'h0)) begin
          if (ulp_cmd) begin // [R10]
            esc_mode <= M_ULP;
            esc_sh <= ULP_CMD;
          end else if (lpd_sel) begin // [R06]
            esc_mode <= M_LPD;
            esc_sh <= LPD_CMD;
          end else begin // [R09]
            esc_mode <= M_TRIG;
            esc_sh <= trig_cmd(trig);
          end
          esc_bits <= 4'h8;
          esc_ent <= 3'h0;
          esc_half <= 1'b0;
          esc_st <= E_SEND;
        end
        E_SEND: if (esc_rise) begin
          if (esc_ent != 3'h4) begin
            TX_LP_LINE <= entry_state(esc_ent);
            esc_ent <= esc_ent + 3'h1;
          end else if (esc_bits != 4'h0) begin
            // Spaced one-hot: mark then space per bit
            esc_half <= ~esc_half;
            if (!esc_half) TX_LP_LINE <= esc_sh[7] ? LP10 : LP01;
            else begin
              TX_LP_LINE <= LP00;
              esc_sh <= {esc_sh[6:0], 1'b0};
              esc_bits <= esc_bits - 4'h1;
            end
          end else if (esc_mode == M_LPD) esc_st <= E_LPD;
          else if (esc_mode == M_ULP) begin
            TX_ULP_ACTIVE_N <= 1'b0; // [R11]
            esc_st <= E_ULP;
          end else esc_st <= E_HOLD;
        end
        E_LPD: if (esc_rise) begin
          if (esc_valid) begin // [R07]
            esc_sh <= esc_data;
            esc_bits <= 4'h8;
            esc_half <= 1'b0;
            esc_st <= E_SEND;
          end else if (!esc_req) begin // [R08]
            TX_LP_LINE <= LP11;
            esc_st <= E_IDLE;
          end
        end
        E_HOLD: if (!esc_req) begin
          TX_LP_LINE <= LP11;
          esc_st <= E_IDLE;
        end
        // Escape clock may be stopped while asleep, so exit is a level on CLK
        E_ULP: if (ulp_exit) begin // [R12]
          TX_ULP_ACTIVE_N <= 1'b1;
          TX_LP_LINE <= LP10;
          wake <= WW'(WAKEUP_CYCLES - 1);
          esc_st <= E_WAKE;
        end
        E_WAKE: if (wake != '0) wake <= wake - WW'(1); // [R23]
          else if (!esc_req) begin // [R13]
            TX_LP_LINE <= LP11;
            esc_st <= E_IDLE;
          end
        default: esc_st <= E_IDLE;
      endcase
    end
  end
  assign TX_ESC_READY = (esc_st == E_LPD);

  // Clock lane sleep
  dpl_clk_t cl_st;
  logic [WW-1:0] cl_cnt;
  always_ff @(posedge CLK) begin
    if (RST) begin
      cl_st <= C_RUN;
      cl_cnt <= '0;
      TX_CLK_LP_LINE <= LP11;
      TX_CLK_ULP_ACTIVE_N <= 1'b1;
    end else begin
      unique case (cl_st)
        C_RUN: if (cu_req) begin
          TX_CLK_LP_LINE <= LP10;
          cl_cnt <= WW'(LPX_CYC - 1);
          cl_st <= C_ENT;
        end
        C_ENT: if (cl_cnt != '0) cl_cnt <= cl_cnt - WW'(1);
          else begin // [R14]
            TX_CLK_LP_LINE <= LP00;
            TX_CLK_ULP_ACTIVE_N <= 1'b0;
            cl_st <= C_ULP;
          end
        C_ULP: if (cu_exit) begin // [R15]
          TX_CLK_ULP_ACTIVE_N <= 1'b1;
          TX_CLK_LP_LINE <= LP10;
          cl_cnt <= WW'(WAKEUP_CYCLES - 1);
          cl_st <= C_WAKE;
        end
        C_WAKE: if (cl_cnt != '0) cl_cnt <= cl_cnt - WW'(1); // [R23]
          else if (!cu_req) begin
            TX_CLK_LP_LINE <= LP11;
            cl_st <= C_RUN;
          end
      endcase
    end
  end

  // High-speed receive; this lane neither aligns nor deskews [R18]
  logic trail;
  always_ff @(posedge CLK) begin
    if (RST) begin
      RX_ACTIVE <= 1'b0;
      RX_SYNC <= 1'b0;
      RX_VALID <= 1'b0;
      RX_DATA <= 8'h00;
      RX_ERR_START <= 1'b0;
      RX_ERR_START_SYNC <= 1'b0;
      trail <= 1'b0;
    end else if (rxb_rise) begin
      RX_SYNC <= 1'b0;
      RX_ERR_START <= 1'b0;
      RX_ERR_START_SYNC <= 1'b0;
      if (!RX_ACTIVE) begin
        if (rx_hs && ctrl[CTRL_RX_EN]) begin // [R16]
          RX_ACTIVE <= 1'b1;
          trail <= 1'b0;
          RX_SYNC <= (bit_errors(rx_hs_data) <= 4'h1);
          RX_ERR_START <= (bit_errors(rx_hs_data) == 4'h1); // [R19]
          RX_ERR_START_SYNC <= (bit_errors(rx_hs_data) > 4'h1); // [R20]
        end
      end else if (rx_hs) begin
        RX_VALID <= 1'b1;
        RX_DATA <= rx_hs_data;
      end else if (!trail) begin // [R17]
        RX_VALID <= 1'b1;
        RX_DATA <= {8{RX_DATA[7]}};
        trail <= 1'b1;
      end else begin
        RX_ACTIVE <= 1'b0;
        RX_VALID <= 1'b0;
      end
    end
  end

  // Low-power receive
  dpl_rxe_t re_st;
  logic [1:0] lp_prev;
  logic [7:0] re_sh;
  logic [2:0] re_bits;
  logic cmd_done;
  always_ff @(posedge CLK) begin
    if (RST) begin
      re_st <= R_STOP;
      lp_prev <= LP11;
      re_sh <= 8'h00;
      re_bits <= 3'h0;
      cmd_done <= 1'b0;
      RX_ESC_CLK <= 1'b0;
      RX_LPD <= 1'b0;
      RX_ESC_VALID <= 1'b0;
      RX_ESC_DATA <= 8'h00;
    end else begin
      lp_prev <= rx_lp;
      RX_ESC_CLK <= rx_lp[1] ^ rx_lp[0]; // [R21]
      if (rx_lp != lp_prev) begin
        if (rx_lp == LP11) begin
          re_st <= R_STOP;
          RX_LPD <= 1'b0;
          RX_ESC_VALID <= 1'b0;
        end else begin
          unique case (re_st)
            R_STOP: re_st <= (rx_lp == LP10) ? R_M1 : R_STOP;
            R_M1: re_st <= (rx_lp == LP00) ? R_SP1 : R_STOP;
            R_SP1: re_st <= (rx_lp == LP01) ? R_M2 : R_STOP;
            R_M2: if (rx_lp == LP00) begin
              re_st <= R_ESC;
              re_bits <= 3'h0;
              cmd_done <= 1'b0;
            end else re_st <= R_STOP;
            R_ESC: if (rx_lp != LP00) begin
              re_sh <= {re_sh[6:0], rx_lp == LP10};
              re_bits <= re_bits + 3'h1;
              RX_ESC_VALID <= 1'b0; // [R22]
              if (re_bits == 3'h7) begin
                cmd_done <= 1'b1;
                if (!cmd_done) RX_LPD <= ({re_sh[6:0], rx_lp == LP10} == LPD_CMD); // [R21]
                else if (RX_LPD) begin
                  RX_ESC_DATA <= {re_sh[6:0], rx_lp == LP10};
                  RX_ESC_VALID <= 1'b1; // [R22]
                end
              end
            end
            default: re_st <= R_STOP;
          endcase
        end
      end
    end
  end

  // Checks
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  logic [7:0] st_age;
  always_ff @(posedge CLK) begin
    if (RST || hs_st != HS_START) st_age <= 8'h00;
    else if (st_age != 8'hFF) st_age <= st_age + 8'h01;
  end
  sequence clk_wake_s;
    TX_CLK_ULP_ACTIVE_N && TX_CLK_LP_LINE == LP10;
  endsequence
  sequence ack_pulse_s;
    ACK_O ##1 !ACK_O;
  endsequence
  hs_start_delay_a: assert property ($rose(TX_HS_READY) |-> $past(st_age) == 8'(STARTUP_CYC - 1)) // [R05]
    else $error("HS ready rose before start delay");
  hs_ready_drop_a: assert property (TX_HS_READY && !hs_req |=> !TX_HS_READY) // [R03]
    else $error("HS ready held after request fell");
  hs_clk_req_a: assert property ($rose(hs_st == HS_START) |-> $past(clk_hs_req && hs_req)) // [R04]
    else $error("HS started without both requests");
  esc_ready_drop_a: assert property (TX_ESC_READY && esc_rise && !esc_valid && !esc_req |=> !TX_ESC_READY) // [R08]
    else $error("Escape ready held after request fell");
  ulp_ind_low_a: assert property ($fell(TX_ULP_ACTIVE_N) |-> esc_mode == M_ULP && TX_LP_LINE == LP00) // [R11]
    else $error("Sleep indicator fell without sleep command");
  wake_mark_a: assert property ($rose(TX_ULP_ACTIVE_N) |-> TX_LP_LINE == LP10 [*8]) // [R12]
    else $error("No mark-one after sleep exit");
  clk_wake_a: assert property ($rose(TX_CLK_ULP_ACTIVE_N) |-> clk_wake_s [*8]) // [R15]
    else $error("Clock lane exit without mark-one");
  start_loss_a: assert property (RX_ERR_START_SYNC |-> !RX_SYNC && RX_ACTIVE) // [R20]
    else $error("Sync pulse with sync-loss error");
  start_soft_a: assert property ($rose(RX_ERR_START) |-> RX_SYNC && $rose(RX_ACTIVE)) // [R19]
    else $error("Soft error without sync pulse");
  rx_end_a: assert property ($fell(RX_ACTIVE) |-> $fell(RX_VALID)) // [R17]
    else $error("Active and valid did not fall together");
  wb_ack_a: assert property (CYC_I && STB_I && !ACK_O |=> ack_pulse_s)
    else $error("Bus answer not a one-cycle pulse");
endmodule : dpl_lane

// ==== inc/dpl_pkg.sv ====
package dpl_pkg;
  // Register map (byte addresses)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam int CTRL_HS_EN = 0;
  localparam int CTRL_RX_EN = 1;
  localparam logic [1:0] CTRL_RESET = 2'h3;
  // Timing, ns and derived cycles at CLK
  localparam int CLK_NS = 10;
  localparam int LPX_NS = 50;
  localparam int HS_PREP_NS = 90;
  localparam int HS_ZERO_NS = 170;
  localparam int CDC_FIX_NS = 30;
  localparam int BYTE_CLK_NS = 160;
  localparam int STARTUP_NS = 2 * LPX_NS + HS_PREP_NS + HS_ZERO_NS + CDC_FIX_NS + 2 * BYTE_CLK_NS;
  localparam int STARTUP_CYC = (STARTUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int LPX_CYC = (LPX_NS + CLK_NS - 1) / CLK_NS;
  localparam int WAKEUP_NS = 1000000;
  localparam int WAKEUP_CYC = (WAKEUP_NS + CLK_NS - 1) / CLK_NS;
  // Line codes
  localparam logic [7:0] START_PATTERN = 8'hB8;
  localparam logic [7:0] LPD_CMD = 8'hE1;
  localparam logic [7:0] ULP_CMD = 8'h1E;
  localparam logic [7:0] TRIG0_CMD = 8'h62;
  localparam logic [7:0] TRIG1_CMD = 8'h5D;
  localparam logic [7:0] TRIG2_CMD = 8'h21;
  localparam logic [7:0] TRIG3_CMD = 8'hA0;
  localparam logic [1:0] LP11 = 2'h3;
  localparam logic [1:0] LP10 = 2'h2;
  localparam logic [1:0] LP01 = 2'h1;
  localparam logic [1:0] LP00 = 2'h0;
  typedef enum logic [1:0] {HS_IDLE, HS_START, HS_SEND} dpl_hs_t;
  typedef enum logic [2:0] {E_IDLE, E_SEND, E_LPD, E_HOLD, E_ULP, E_WAKE} dpl_esc_t;
  typedef enum logic [1:0] {M_LPD, M_ULP, M_TRIG} dpl_mode_t;
  typedef enum logic [1:0] {C_RUN, C_ENT, C_ULP, C_WAKE} dpl_clk_t;
  typedef enum logic [2:0] {R_STOP, R_M1, R_SP1, R_M2, R_ESC} dpl_rxe_t;
endpackage : dpl_pkg

// ==== verification/dpl_proto_model.sv ====
`timescale 1ns/100ps
// Protocol side of the HS transmit lane: byte clock runs only inside a burst
module dpl_proto_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic go,
  input wire logic [7:0] nbytes,
  input wire logic ready,
  output logic byte_clk,
  output logic hs_req,
  output logic clk_hs_req,
  output logic [7:0] data
);
  logic [2:0] cnt;
  logic [7:0] sent;
  logic took;
  always_ff @(posedge clk) begin
    if (rst || !go) begin
      cnt <= 3'h0;
      sent <= 8'h00;
      took <= 1'b0;
      byte_clk <= 1'b0;
      hs_req <= 1'b0;
      clk_hs_req <= 1'b0;
      data <= rst ? 8'h5A : ~data; // Idle bus keeps toggling so ignored data never looks stable
    end else if (sent != nbytes) begin
      clk_hs_req <= 1'b1; // Clock lane raised in the same cycle as data lane
      hs_req <= 1'b1;
      cnt <= cnt + 3'h1;
      if (!hs_req) begin
        data <= 8'hA0;
      end
      if (cnt == 3'h7) begin
        byte_clk <= ~byte_clk;
        took <= byte_clk ? took : ready;
        if (byte_clk && took) begin
          sent <= sent + 8'h01;
          data <= data + 8'h01; // Next byte only after a taking edge
        end
      end
    end else begin
      hs_req <= 1'b0;
      clk_hs_req <= 1'b0;
      byte_clk <= 1'b0;
    end
  end
endmodule : dpl_proto_model

// ==== verification/dpl_lane_tb.sv ====
`timescale 1ns/100ps
module dpl_lane_tb import dpl_pkg::*;;
  localparam int WAKE = 50;
  logic CLK = 1'b0, RST = 1'b1, CYC_I = 1'b0, STB_I = 1'b0, WE_I = 1'b0, go = 1'b0;
  logic [3:0] ADR_I = 4'h0, SEL_I = 4'hF, TX_TRIGGER = 4'h0;
  logic [31:0] DAT_I = 32'h0000_0000, DAT_O, q;
  logic ACK_O, TX_BYTE_CLK, TX_HS_REQ, TX_CLK_HS_REQ, TX_HS_READY, TX_HS_LINE_EN;
  logic [7:0] TX_HS_DATA, TX_HS_LINE_DATA, TX_ESC_DATA = 8'h00, RX_HS_LINE_DATA = 8'h00, RX_DATA, RX_ESC_DATA;
  logic [7:0] nbytes = 8'h03;
  logic TX_ESC_CLK = 1'b0, TX_ESC_REQ = 1'b0, TX_LPD_SEL = 1'b0, TX_ESC_VALID = 1'b0, TX_ULP_CMD = 1'b0;
  logic TX_ULP_EXIT = 1'b0, TX_ESC_READY, TX_ULP_ACTIVE_N, TX_CLK_ULP_REQ = 1'b0, TX_CLK_ULP_EXIT = 1'b0;
  logic TX_CLK_ULP_ACTIVE_N, RX_BYTE_CLK = 1'b0, RX_HS_LINE = 1'b0, RX_ACTIVE, RX_SYNC, RX_VALID;
  logic RX_ERR_START, RX_ERR_START_SYNC, RX_ESC_CLK, RX_LPD, RX_ESC_VALID;
  logic [1:0] TX_LP_LINE, TX_CLK_LP_LINE, RX_LP_LINE = 2'h3;
  int errors = 0, total_checks = 0;

  always #5 CLK = ~CLK;

  dpl_lane #(.WAKEUP_CYCLES(WAKE)) dpl_lane_inst (.CLK(CLK), .RST(RST), .CYC_I(CYC_I), .STB_I(STB_I),
    .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
    .TX_BYTE_CLK(TX_BYTE_CLK), .TX_HS_REQ(TX_HS_REQ), .TX_HS_DATA(TX_HS_DATA), .TX_CLK_HS_REQ(TX_CLK_HS_REQ),
    .TX_HS_READY(TX_HS_READY), .TX_HS_LINE_EN(TX_HS_LINE_EN), .TX_HS_LINE_DATA(TX_HS_LINE_DATA),
    .TX_ESC_CLK(TX_ESC_CLK), .TX_ESC_REQ(TX_ESC_REQ), .TX_LPD_SEL(TX_LPD_SEL), .TX_ESC_VALID(TX_ESC_VALID),
    .TX_ESC_DATA(TX_ESC_DATA), .TX_TRIGGER(TX_TRIGGER), .TX_ULP_CMD(TX_ULP_CMD), .TX_ULP_EXIT(TX_ULP_EXIT),
    .TX_ESC_READY(TX_ESC_READY), .TX_ULP_ACTIVE_N(TX_ULP_ACTIVE_N), .TX_LP_LINE(TX_LP_LINE),
    .TX_CLK_ULP_REQ(TX_CLK_ULP_REQ), .TX_CLK_ULP_EXIT(TX_CLK_ULP_EXIT),
    .TX_CLK_ULP_ACTIVE_N(TX_CLK_ULP_ACTIVE_N), .TX_CLK_LP_LINE(TX_CLK_LP_LINE), .RX_BYTE_CLK(RX_BYTE_CLK),
    .RX_HS_LINE(RX_HS_LINE), .RX_HS_LINE_DATA(RX_HS_LINE_DATA), .RX_LP_LINE(RX_LP_LINE), .RX_ACTIVE(RX_ACTIVE),
    .RX_SYNC(RX_SYNC), .RX_VALID(RX_VALID), .RX_DATA(RX_DATA), .RX_ERR_START(RX_ERR_START),
    .RX_ERR_START_SYNC(RX_ERR_START_SYNC), .RX_ESC_CLK(RX_ESC_CLK), .RX_LPD(RX_LPD), .RX_ESC_VALID(RX_ESC_VALID),
    .RX_ESC_DATA(RX_ESC_DATA));
  dpl_proto_model dpl_proto_model_inst (.clk(CLK), .rst(RST), .go(go), .nbytes(nbytes), .ready(TX_HS_READY),
    .byte_clk(TX_BYTE_CLK), .hs_req(TX_HS_REQ), .clk_hs_req(TX_CLK_HS_REQ), .data(TX_HS_DATA));

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s: expected %h, seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
  endtask : tick

  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d, output logic [31:0] rd);
    int n;
    n = 0;
    CYC_I <= 1'b1;
    STB_I <= 1'b1;
    WE_I <= we;
    SEL_I <= 4'hF;
    ADR_I <= a;
    DAT_I <= d;
    do begin
      @(posedge CLK);
      n++;
    end while (ACK_O !== 1'b1 && n < 20);
    rd = DAT_O;
    CYC_I <= 1'b0;
    STB_I <= 1'b0;
    chk("bus ack", 1'b1, ACK_O);
    tick(1);
  endtask : wb

  task automatic esc(input int n);
    repeat (n) begin
      TX_ESC_CLK <= 1'b1;
      tick(8);
      TX_ESC_CLK <= 1'b0;
      tick(8);
    end
  endtask : esc

  // Each half-bit is checked one escape period after its rise
  task automatic sendbits(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      esc(1);
      chk("esc mark", b[i] ? LP10 : LP01, TX_LP_LINE);
      esc(1);
      chk("esc space", LP00, TX_LP_LINE);
    end
  endtask : sendbits

  // Inputs changed with a rise are seen at the following rise
  task automatic t_esc();
    TX_ESC_REQ <= 1'b1;
    TX_LPD_SEL <= 1'b1;
    esc(6);
    sendbits(LPD_CMD);
    esc(1);
    chk("esc ready after command", 1'b1, TX_ESC_READY);
    TX_ESC_VALID <= 1'b1;
    TX_ESC_DATA <= 8'hC3;
    esc(1);
    TX_ESC_VALID <= 1'b0;
    esc(1);
    chk("esc ready while sending", 1'b0, TX_ESC_READY);
    sendbits(8'hC3);
    esc(1);
    chk("esc ready after byte", 1'b1, TX_ESC_READY);
    TX_ESC_REQ <= 1'b0;
    TX_LPD_SEL <= 1'b0;
    esc(2);
    chk("esc lp end", 3'b011, {TX_ESC_READY, TX_LP_LINE});
    TX_ESC_REQ <= 1'b1;
    TX_TRIGGER <= 4'h1;
    esc(6);
    sendbits(TRIG0_CMD);
    esc(8);
    TX_ESC_REQ <= 1'b0; // Released after 30 escape cycles
    TX_TRIGGER <= 4'h0;
    tick(6);
    chk("trigger end", 2'h3, TX_LP_LINE);
    $display("test escape transmit done");
  endtask : t_esc

  task automatic rxb(input logic hs, input logic [7:0] d);
    RX_HS_LINE <= hs;
    RX_HS_LINE_DATA <= d;
    tick(8);
    RX_BYTE_CLK <= 1'b1;
    tick(8);
    RX_BYTE_CLK <= 1'b0;
  endtask : rxb

  task automatic lp(input logic [1:0] st);
    RX_LP_LINE <= st;
    tick(8);
  endtask : lp

  task automatic lpbyte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      lp(b[i] ? LP10 : LP01);
      lp(LP00);
    end
  endtask : lpbyte

  task automatic t_regs();
    wb(1'b0, REG_CTRL, 32'h0000_0000, q);
    chk("ctrl reset", 32'h0000_0003, q);
    wb(1'b0, REG_STATUS, 32'h0000_0000, q);
    chk("status idle", 32'h0000_0030, q);
    wb(1'b0, 4'h8, 32'h0000_0000, q);
    chk("unmapped read", 32'h0000_0000, q);
    wb(1'b1, REG_CTRL, 32'h0000_0002, q);
    wb(1'b0, REG_CTRL, 32'h0000_0000, q);
    chk("ctrl written", 32'h0000_0002, q);
    go <= 1'b1;
    tick(120);
    chk("hs refused when disabled", 2'b00, {TX_HS_READY, TX_HS_LINE_EN});
    go <= 1'b0;
    wb(1'b1, REG_CTRL, 32'h0000_0003, q);
    $display("test registers done");
  endtask : t_regs

  task automatic t_hs(input logic [7:0] n);
    int c;
    logic [7:0] last;
    logic [7:0] got[$];
    c = 0;
    last = 8'h00;
    nbytes <= n;
    go <= 1'b1;
    while (TX_HS_READY !== 1'b1 && c < 200) begin
      tick(1);
      c++;
    end
    chk("hs start delay", 1'b1, c >= STARTUP_CYC + 1 && c <= STARTUP_CYC + 7);
    repeat (40 * n + 40) begin
      tick(1);
      if (TX_HS_READY === 1'b1 && TX_HS_LINE_DATA !== last) begin
        last = TX_HS_LINE_DATA;
        got.push_back(last);
      end
    end
    chk("hs byte count", n, got.size());
    foreach (got[i]) chk("hs byte", 8'hA0 + i, got[i]);
    chk("hs ready after drop", 2'b00, {TX_HS_READY, TX_HS_LINE_EN});
    go <= 1'b0;
    tick(2);
    $display("test hs transmit done");
  endtask : t_hs

  task automatic t_rx(input logic [7:0] pat, input logic [2:0] flags);
    rxb(1'b1, pat);
    chk("rx start flags", {1'b1, flags}, {RX_ACTIVE, RX_SYNC, RX_ERR_START, RX_ERR_START_SYNC});
    rxb(1'b1, 8'h3C);
    chk("rx byte 1", 9'h13C, {RX_VALID, RX_DATA});
    rxb(1'b1, 8'hC5);
    chk("rx byte 2", 9'h1C5, {RX_VALID, RX_DATA});
    rxb(1'b0, 8'h00);
    chk("rx filler", 8'hFF, RX_DATA);
    rxb(1'b0, 8'h00);
    chk("rx end", 2'b00, {RX_ACTIVE, RX_VALID});
    tick(20);
    $display("test hs receive done");
  endtask : t_rx

  task automatic t_lp();
    lp(LP10);
    chk("rx esc clock mark", 1'b1, RX_ESC_CLK);
    lp(LP00);
    chk("rx esc clock space", 1'b0, RX_ESC_CLK);
    lp(LP01);
    lp(LP00);
    lpbyte(LPD_CMD);
    chk("rx lp mode", 1'b1, RX_LPD);
    lpbyte(8'h5A);
    chk("rx lp byte", 9'h15A, {RX_ESC_VALID, RX_ESC_DATA});
    lp(LP11);
    chk("rx lp end", 1'b0, RX_LPD);
    $display("test lp receive done");
  endtask : t_lp

  task automatic t_ulp();
    int c;
    c = 0;
    TX_ESC_REQ <= 1'b1;
    TX_ULP_CMD <= 1'b1;
    esc(1);
    TX_ULP_CMD <= 1'b0; // One escape cycle only
    esc(22);
    chk("data lane asleep", 3'b000, {TX_ULP_ACTIVE_N, TX_LP_LINE});
    TX_ULP_EXIT <= 1'b1;
    tick(4);
    TX_ULP_EXIT <= 1'b0;
    tick(2);
    chk("data lane wake", 3'b110, {TX_ULP_ACTIVE_N, TX_LP_LINE});
    tick(WAKE - 10);
    chk("data lane mark one", 2'h2, TX_LP_LINE);
    tick(20);
    TX_ESC_REQ <= 1'b0;
    tick(6);
    chk("data lane stop", 2'h3, TX_LP_LINE);
    TX_CLK_ULP_REQ <= 1'b1;
    while (TX_CLK_ULP_ACTIVE_N !== 1'b0 && c < 40) begin
      tick(1);
      c++;
    end
    chk("clock lane entry time", 1'b1, c >= LPX_CYC && c < LPX_CYC + 8);
    chk("clock lane asleep", 2'h0, TX_CLK_LP_LINE);
    TX_CLK_ULP_EXIT <= 1'b1;
    tick(4);
    TX_CLK_ULP_EXIT <= 1'b0;
    tick(2);
    chk("clock lane wake", 3'b110, {TX_CLK_ULP_ACTIVE_N, TX_CLK_LP_LINE});
    tick(WAKE + 10);
    TX_CLK_ULP_REQ <= 1'b0;
    tick(6);
    chk("clock lane stop", 2'h3, TX_CLK_LP_LINE);
    $display("test sleep modes done");
  endtask : t_ulp

  task automatic summarize();
    $display("checks %0d, mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize

  initial begin
    tick(5);
    RST <= 1'b0;
    tick(1);
    chk("reset outputs", 14'h03F0, {ACK_O, TX_HS_READY, TX_HS_LINE_EN, TX_ESC_READY, TX_ULP_ACTIVE_N,
      TX_CLK_ULP_ACTIVE_N, TX_LP_LINE, TX_CLK_LP_LINE, RX_ACTIVE, RX_VALID, RX_LPD, RX_ESC_VALID});
    tick(3);
    t_regs();
    t_hs(8'h03);
    t_hs(8'h01);
    t_rx(START_PATTERN, 3'b100);
    t_rx(START_PATTERN ^ 8'h01, 3'b110);
    t_rx(~START_PATTERN, 3'b001);
    t_lp();
    t_esc();
    t_ulp();
    summarize();
  end

  // Whole run needs well under 10k cycles
  initial begin
    #100000;
    errors++;
    summarize();
  end
endmodule : dpl_lane_tb
